// [verilog/rsc_pkg.sv]
/*
  shared constants and carrier types for the reset and strap
  configuration block of a four-port hub.
  assumes a single 25 MHz core clock and no register bus.
*/
`default_nettype none

package rsc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 25_000_000;  // core clock rate
  localparam int unsigned RESET_MIN_MS   = 3;           // least global reset low time
  // least time rounds up to whole cycles
  localparam int unsigned RESET_MIN_CYC  = (RESET_MIN_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned RESET_CNT_W    = 17;          // width of the low-time counter

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PORT_COUNT     = 4;           // downstream ports
  localparam int unsigned SYNC_STAGES    = 3;           // pin synchroniser depth

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // straps as seen on the pins, one bit each
  typedef struct packed {
    logic global_reset_n;   // external active-low global reset
    logic bus_mode;         // high: eeprom mode, low: smbus mode
    logic serial_data;      // high: u1/u2 disabled
    logic serial_clock;     // high: u1/u2 initiation blocked
    logic hs_polarity;      // high: power enables active high
    logic ss_spread;        // high: spread spectrum off
  } rsc_pins_t;

  localparam rsc_pins_t PINS_RST = 6'h00;  // synchroniser contents at reset

  // captured strap set, held between resets
  typedef struct packed {
    logic bus_mode;
    logic serial_data;
    logic serial_clock;
    logic hs_polarity;
    logic ss_spread;
  } rsc_straps_t;

  // defaults before the first capture: eeprom mode, everything enabled
  localparam rsc_straps_t STRAPS_RST = 5'h10;

endpackage

`default_nettype wire

// [verilog/rsc_pin_sync.sv]
/*
  three-stage synchroniser for a group of pins.
  the output follows once the second and third stages agree.
  assumes pins are asynchronous to clock_in.
*/
`timescale 1ns/10ps
`default_nettype none

module rsc_pin_sync #(
  parameter int unsigned           WIDTH     = 1,
  parameter logic [WIDTH-1:0]      RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] meta_reg;   // first stage, read only by stage two
  logic [WIDTH-1:0] mid_reg;    // second stage
  logic [WIDTH-1:0] late_reg;   // third stage

  // ----------------------------------------------------------------
  // shift chain
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= RESET_VAL;
      mid_reg  <= RESET_VAL;
      late_reg <= RESET_VAL;
    end else begin
      meta_reg <= pins_in;
      mid_reg  <= meta_reg;
      late_reg <= mid_reg;
    end
  end

  // ----------------------------------------------------------------
  // agreement filter: a bit moves only when stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stable_out <= RESET_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (mid_reg[i] == late_reg[i]) begin
          stable_out[i] <= late_reg[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// [verilog/rsc_reset_strap_config.sv]
/*
  reset handling and power-on strap capture for a four-port hub.
  holds the hub core in reset while the global reset pin is low,
  captures the straps once at its release and drives the resulting
  configuration, the serial pin routing, the port power enables and
  the suspend status leds.
  assumes rst_n_in is a power-on reset and all strap pins are async.
*/
// What this block does
// - core held in reset while global reset low
// - bus-mode strap high eeprom, low smbus
// - serial pins routed to smbus or eeprom
// - data strap high disables u1 and u2
// - config register overrides u1u2 disable strap
// - clock strap high blocks u1u2 initiation
// - blocked: accept requests, never initiate
// - config register overrides initiation block strap
// - power enables active low unless strap high
// - spread spectrum off when strap high
// - suspend strap pins become status leds
// - port power enables use captured polarity
`timescale 1ns/10ps
`default_nettype none

module rsc_reset_strap_config #(
  parameter int unsigned RESET_MIN_CYC = rsc_pkg::RESET_MIN_CYC,  // least low time
  parameter int unsigned PORTS         = rsc_pkg::PORT_COUNT       // downstream ports
) (
  // clock and power-on reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // global reset and strap pins
  input  wire logic             global_reset_n_in,
  input  wire logic             bus_mode_strap_in,
  input  wire logic             serial_data_strap_pin_in,
  input  wire logic             serial_clock_strap_pin_in,
  input  wire logic             hs_suspend_led_polarity_strap_in,
  input  wire logic             ss_suspend_led_spread_strap_in,
  // configuration register bits from the eeprom or smbus loader
  input  wire logic             config_source_valid_in,
  input  wire logic             link_low_power_disable_bit_in,
  input  wire logic             low_power_initiation_block_bit_in,
  // serial engines: open-drain enables and received levels
  input  wire logic             eeprom_clock_oe_in,
  input  wire logic             eeprom_data_oe_in,
  input  wire logic             smbus_data_oe_in,
  output logic                  eeprom_clock_rx_out,
  output logic                  eeprom_data_rx_out,
  output logic                  smbus_clock_rx_out,
  output logic                  smbus_data_rx_out,
  output logic                  serial_clock_oe_out,
  output logic                  serial_data_oe_out,
  output logic                  serial_pins_out,
  // link low-power control
  input  wire logic             lp_entry_request_in,
  input  wire logic             lp_self_initiate_in,
  output logic                  lp_entry_accept_out,
  output logic                  lp_initiate_out,
  // port power
  input  wire logic [PORTS-1:0] port_power_request_in,
  output logic      [PORTS-1:0] port_power_enable_n_out,
  // suspend status leds on the strap pins
  input  wire logic             hs_suspended_in,
  input  wire logic             ss_suspended_in,
  output logic                  hs_suspend_led_out,
  output logic                  hs_suspend_led_oe_out,
  output logic                  ss_suspend_led_out,
  output logic                  ss_suspend_led_oe_out,
  // configuration and status
  output logic                  core_reset_n_out,
  output logic                  smbus_mode_out,
  output logic                  u1u2_disable_out,
  output logic                  u1u2_init_block_out,
  output logic                  spread_spectrum_en_out,
  output logic                  reset_too_short_out
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (RESET_MIN_CYC < 1 || RESET_MIN_CYC >= (1 << rsc_pkg::RESET_CNT_W)) begin : g_bad_min
    $error("RESET_MIN_CYC out of counter range");
  end
  if (PORTS < 1) begin : g_bad_ports
    $error("PORTS must be at least one");
  end

  typedef enum logic [0:0] {ST_HOLD, ST_RUN} rsc_state_t;

  rsc_pkg::rsc_pins_t                  pins_raw;     // raw pin group
  rsc_pkg::rsc_pins_t                  pins_s;       // synchronised pins
  rsc_state_t                          state_reg;    // core reset state
  rsc_pkg::rsc_straps_t                straps_reg;   // captured straps
  logic [rsc_pkg::RESET_CNT_W-1:0]     low_cnt_reg;  // cycles of reset low
  logic                                capture;      // release seen this cycle
  logic                                dis_eff;      // effective u1u2 disable
  logic                                blk_eff;      // effective initiation block

  assign pins_raw = '{global_reset_n : global_reset_n_in,
                      bus_mode       : bus_mode_strap_in,
                      serial_data    : serial_data_strap_pin_in,
                      serial_clock   : serial_clock_strap_pin_in,
                      hs_polarity    : hs_suspend_led_polarity_strap_in,
                      ss_spread      : ss_suspend_led_spread_strap_in};

  // straps pass the same chain as the reset pin so they line up with its release
  rsc_pin_sync #(
    .WIDTH     ($bits(rsc_pkg::rsc_pins_t)),
    .RESET_VAL (rsc_pkg::PINS_RST)
  ) u_sync (
    .clock_in   (clock_in),
    .rst_n_in   (rst_n_in),
    .pins_in    (pins_raw),
    .stable_out (pins_s)
  );

  assign capture = (state_reg == ST_HOLD) && pins_s.global_reset_n;

  // ----------------------------------------------------------------
  // core reset state
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_HOLD;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          if (pins_s.global_reset_n) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!pins_s.global_reset_n) begin
            state_reg <= ST_HOLD;
          end
        end
        default: begin
          state_reg <= ST_HOLD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // low-time measurement; a short pulse is flagged, not lengthened,
  // since the core cannot know whether supplies were already good
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_cnt_reg         <= '0;
      reset_too_short_out <= 1'b0;
    end else if (capture) begin
      low_cnt_reg         <= '0;
      // the first low cycle is seen while still in ST_RUN and never counted, so the count reads one short of the pin
      reset_too_short_out <= (low_cnt_reg < rsc_pkg::RESET_CNT_W'(RESET_MIN_CYC - 1));
    end else if (state_reg == ST_HOLD && low_cnt_reg != '1) begin
      low_cnt_reg         <= low_cnt_reg + 1'b1;  // saturates
    end
  end

  // ----------------------------------------------------------------
  // strap capture: once per release, held through later pin activity
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      straps_reg <= rsc_pkg::STRAPS_RST;
    end else if (capture) begin
      straps_reg <= '{bus_mode     : pins_s.bus_mode,
                      serial_data  : pins_s.serial_data,
                      serial_clock : pins_s.serial_clock,
                      hs_polarity  : pins_s.hs_polarity,
                      ss_spread    : pins_s.ss_spread};
    end
  end

  // ----------------------------------------------------------------
  // effective low-power settings
  // ----------------------------------------------------------------
  always_comb begin
    if (config_source_valid_in) begin
      dis_eff = link_low_power_disable_bit_in;
      blk_eff = low_power_initiation_block_bit_in;
    end else begin
      dis_eff = straps_reg.serial_data;
      blk_eff = straps_reg.serial_clock;
    end
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_reset_n_out       <= 1'b0;
      smbus_mode_out         <= 1'b0;
      u1u2_disable_out       <= 1'b0;
      u1u2_init_block_out    <= 1'b0;
      spread_spectrum_en_out <= 1'b1;
    end else begin
      core_reset_n_out       <= (state_reg == ST_RUN);
      smbus_mode_out         <= !straps_reg.bus_mode;
      u1u2_disable_out       <= dis_eff;
      u1u2_init_block_out    <= blk_eff;
      spread_spectrum_en_out <= !straps_reg.ss_spread;
    end
  end

  // ----------------------------------------------------------------
  // link low-power gating: disable stops everything, block only our own
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lp_entry_accept_out <= 1'b0;
      lp_initiate_out     <= 1'b0;
    end else begin
      lp_entry_accept_out <= lp_entry_request_in && !dis_eff && (state_reg == ST_RUN);
      lp_initiate_out     <= lp_self_initiate_in && !dis_eff && !blk_eff
                             && (state_reg == ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // serial pin routing; drivers off while the core is in reset so the
  // board straps are not fought during sampling
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      serial_clock_oe_out <= 1'b0;
      serial_data_oe_out  <= 1'b0;
    end else if (state_reg != ST_RUN) begin
      serial_clock_oe_out <= 1'b0;
      serial_data_oe_out  <= 1'b0;
    end else if (!straps_reg.bus_mode) begin
      serial_clock_oe_out <= 1'b0;               // clock comes from the smbus host
      serial_data_oe_out  <= smbus_data_oe_in;
    end else begin
      serial_clock_oe_out <= eeprom_clock_oe_in;
      serial_data_oe_out  <= eeprom_data_oe_in;
    end
  end

  // received levels go only to the engine that owns the pins
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eeprom_clock_rx_out <= 1'b1;
      eeprom_data_rx_out  <= 1'b1;
      smbus_clock_rx_out  <= 1'b1;
      smbus_data_rx_out   <= 1'b1;
    end else begin
      eeprom_clock_rx_out <= straps_reg.bus_mode  ? pins_s.serial_clock : 1'b1;
      eeprom_data_rx_out  <= straps_reg.bus_mode  ? pins_s.serial_data  : 1'b1;
      smbus_clock_rx_out  <= !straps_reg.bus_mode ? pins_s.serial_clock : 1'b1;
      smbus_data_rx_out   <= !straps_reg.bus_mode ? pins_s.serial_data  : 1'b1;
    end
  end

  // open-drain: driven level is always low
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      serial_pins_out <= 1'b0;
    end else begin
      serial_pins_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // port power enables; off level follows the captured polarity
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_power_enable_n_out <= '1;   // active-low default means all off
    end else if (state_reg != ST_RUN) begin
      port_power_enable_n_out <= {PORTS{!straps_reg.hs_polarity}};
    end else if (straps_reg.hs_polarity) begin
      port_power_enable_n_out <= port_power_request_in;
    end else begin
      port_power_enable_n_out <= ~port_power_request_in;
    end
  end

  // ----------------------------------------------------------------
  // suspend leds: pins are released during reset so straps can be read
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hs_suspend_led_out    <= 1'b0;
      hs_suspend_led_oe_out <= 1'b0;
      ss_suspend_led_out    <= 1'b0;
      ss_suspend_led_oe_out <= 1'b0;
    end else begin
      hs_suspend_led_oe_out <= (state_reg == ST_RUN);
      ss_suspend_led_oe_out <= (state_reg == ST_RUN);
      hs_suspend_led_out    <= hs_suspended_in && (state_reg == ST_RUN);
      ss_suspend_led_out    <= ss_suspended_in && (state_reg == ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  core_reset_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !pins_s.global_reset_n && state_reg == ST_RUN |-> ##2 !core_reset_n_out)
    else $error("core left running after global reset fell");

  short_flag_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    capture |=> reset_too_short_out == ($past(low_cnt_reg) < RESET_MIN_CYC - 1))
    else $error("short reset flag wrong at release");

  bus_mode_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    capture |-> ##2 (smbus_mode_out == !$past(pins_s.bus_mode, 2)))
    else $error("bus mode not taken from strap");

  serial_route_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state_reg == ST_RUN && straps_reg.bus_mode |=>
      serial_data_oe_out == $past(eeprom_data_oe_in))
    else $error("eeprom mode data enable misrouted");

  lp_disable_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    config_source_valid_in |=> u1u2_disable_out == $past(link_low_power_disable_bit_in))
    else $error("u1u2 disable not from config bit");

  init_block_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !config_source_valid_in |=> u1u2_init_block_out == $past(straps_reg.serial_clock))
    else $error("initiation block not from strap");

  no_initiate_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    lp_initiate_out |-> !$past(blk_eff) && !$past(dis_eff))
    else $error("initiated low power while blocked");

  accept_blocked_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state_reg == ST_RUN && lp_entry_request_in && !dis_eff && blk_eff |=> lp_entry_accept_out)
    else $error("request refused while only initiation blocked");

  power_pol_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state_reg == ST_RUN && !straps_reg.hs_polarity |=>
      port_power_enable_n_out == ~$past(port_power_request_in))
    else $error("active-low power enable wrong");

  strap_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state_reg == ST_RUN |=> $stable(straps_reg))
    else $error("captured straps changed while running");

  led_drive_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state_reg == ST_HOLD |=> !hs_suspend_led_oe_out && !ss_suspend_led_oe_out)
    else $error("led pins driven during strap sampling");

endmodule

`default_nettype wire

// [sim/rsc_board_model.sv]
/*
  board model: the external global reset source and the strap
  resistors, with the open-drain and led pins resolved to levels.
  assumes the bench asks for each reset pulse and gives its length.
*/
`timescale 1ns/10ps
`default_nettype none

module rsc_board_model (
  // clock and bench requests
  input  wire logic       clock_in,
  input  wire logic       pulse_in,
  input  wire logic [7:0] hold_cyc_in,
  input  wire logic [4:0] strap_in,
  // device drive: {clock oe, data oe, hs led oe, ss led oe}
  input  wire logic [3:0] oe_in,
  input  wire logic [1:0] led_in,
  // levels seen by the device: {bus, data, clock, hs, ss}
  output logic            global_reset_n_out,
  output logic [4:0]      pin_out
);
  // ----------------------------------------------------------------
  // reset source
  // ----------------------------------------------------------------
  logic [7:0] cnt_reg = 8'h00;  // low cycles still to go

  // a request reloads the low time, so pulses may be short or long
  always @(posedge clock_in) begin
    if (pulse_in) begin
      cnt_reg <= hold_cyc_in;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  assign global_reset_n_out = (cnt_reg == 8'h00);

  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  // board resistors beat the weak internal pulls, so the strap shows
  // unless the device pulls low or drives its led
  assign pin_out[4] = strap_in[4];
  assign pin_out[3] = oe_in[2] ? 1'b0 : strap_in[3];
  assign pin_out[2] = oe_in[3] ? 1'b0 : strap_in[2];
  assign pin_out[1] = oe_in[1] ? led_in[1] : strap_in[1];
  assign pin_out[0] = oe_in[0] ? led_in[0] : strap_in[0];
endmodule

`default_nettype wire

// [sim/rsc_reset_strap_config_test.sv]
/*
  self-checking bench: boots the block with several strap sets and
  checks capture, override, routing, power and led behaviour.
  assumes the board model supplies reset pulses and pin levels.
*/
`timescale 1ns/10ps
`default_nettype none

module rsc_reset_strap_config_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int unsigned MIN_CYC = 20;  // shortened least low time
  logic clock_in = 1'b0, rst_n_in = 1'b0, pulse = 1'b0, cfg_v = 1'b0;
  logic dis_b = 1'b0, blk_b = 1'b0, lp_req = 1'b0, lp_ini = 1'b0;
  logic hs_s = 1'b0, ss_s = 1'b0, s_dat_oe = 1'b0, e_oe = 1'b0, grst_n;
  logic [7:0] hold = 8'h1E;
  logic [4:0] straps = 5'h10, pins;
  logic [3:0] req = 4'hA, oes, pwr_n;
  logic [1:0] leds;
  logic e_crx, e_drx, s_crx, s_drx, acc, ini, core_n, smb, dis, blk, ssc, short;
  int err_total = 0, n_tests = 0, cyc = 0, i;
  // hold length and straps for each boot; 8'h08 is a short pulse, 8'h14 sits on the limit
  logic [12:0] rows [5] = '{13'h03DF, 13'h03C0, 13'h0113, 13'h0293, 13'h03C4};

  always #20 clock_in = ~clock_in;

  rsc_board_model i_rsc_board_model (
    .clock_in(clock_in), .pulse_in(pulse), .hold_cyc_in(hold), .strap_in(straps),
    .oe_in(oes), .led_in(leds), .global_reset_n_out(grst_n), .pin_out(pins));

  rsc_reset_strap_config #(.RESET_MIN_CYC(MIN_CYC), .PORTS(4)) i_rsc_reset_strap_config (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .global_reset_n_in(grst_n),
    .bus_mode_strap_in(pins[4]), .serial_data_strap_pin_in(pins[3]),
    .serial_clock_strap_pin_in(pins[2]), .hs_suspend_led_polarity_strap_in(pins[1]),
    .ss_suspend_led_spread_strap_in(pins[0]), .config_source_valid_in(cfg_v),
    .link_low_power_disable_bit_in(dis_b), .low_power_initiation_block_bit_in(blk_b),
    .eeprom_clock_oe_in(e_oe), .eeprom_data_oe_in(e_oe), .smbus_data_oe_in(s_dat_oe),
    .eeprom_clock_rx_out(e_crx), .eeprom_data_rx_out(e_drx), .smbus_clock_rx_out(s_crx),
    .smbus_data_rx_out(s_drx), .serial_clock_oe_out(oes[3]), .serial_data_oe_out(oes[2]),
    .serial_pins_out(), .lp_entry_request_in(lp_req), .lp_self_initiate_in(lp_ini),
    .lp_entry_accept_out(acc), .lp_initiate_out(ini), .port_power_request_in(req),
    .port_power_enable_n_out(pwr_n), .hs_suspended_in(hs_s), .ss_suspended_in(ss_s),
    .hs_suspend_led_out(leds[1]), .hs_suspend_led_oe_out(oes[1]),
    .ss_suspend_led_out(leds[0]), .ss_suspend_led_oe_out(oes[0]),
    .core_reset_n_out(core_n), .smbus_mode_out(smb), .u1u2_disable_out(dis),
    .u1u2_init_block_out(blk), .spread_spectrum_en_out(ssc), .reset_too_short_out(short));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // drives land by non-blocking assignment right after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // bounded wait, checks settled values away from the rising edge
  task automatic wait_core(input logic lvl);
    int k;
    for (k = 0; k < 200 && core_n !== lvl; k++) @(negedge clock_in);
    chk1("core_reset_n", lvl, core_n);
  endtask

  task automatic boot(input logic [4:0] s, input logic [7:0] h);
    tick(1);
    straps <= s;
    hold <= h;
    pulse <= 1'b1;
    e_oe <= ~e_oe;  // eeprom engine pull alternates from boot to boot
    tick(1);
    pulse <= 1'b0;
    wait_core(1'b0);
    wait_core(1'b1);
    tick(6);
    @(negedge clock_in);
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(2);
    rst_n_in <= 1'b1;
    wait_core(1'b1);
    for (i = 0; i < 5; i++) begin
      boot(rows[i][4:0], rows[i][12:5]);
      chk1("smbus_mode", ~rows[i][4], smb);
      chk1("u1u2_disable", rows[i][3], dis);
      chk1("init_block", rows[i][2], blk);
      chk1("ssc_enable", ~rows[i][0], ssc);
      chk4("power_enable_n", rows[i][1] ? 4'hA : 4'h5, pwr_n);
      chk1("hs_led_oe", 1'b1, oes[1]);
      chk1("ss_led_oe", 1'b1, oes[0]);
      chk1("serial_clock_oe", rows[i][4] & e_oe, oes[3]);
      chk1("eeprom_clock_rx", rows[i][4] ? rows[i][2] & ~e_oe : 1'b1, e_crx);
      chk1("smbus_clock_rx", rows[i][4] ? 1'b1 : rows[i][2], s_crx);
      chk1("too_short", rows[i][12:5] < MIN_CYC, short);
    end
    // no new boot: the last capture (smbus mode, initiation blocked) holds while every strap pin flips
    tick(1);
    straps <= 5'h1B;
    lp_req <= 1'b1;
    lp_ini <= 1'b1;
    hs_s <= 1'b1;
    ss_s <= 1'b1;
    tick(5);
    @(negedge clock_in);
    chk1("smbus_mode", 1'b1, smb);
    chk1("ssc_enable", 1'b1, ssc);
    chk4("power_enable_n", 4'h5, pwr_n);
    chk1("lp_accept", 1'b1, acc);
    chk1("lp_initiate", 1'b0, ini);
    chk1("hs_led", 1'b1, leds[1]);
    chk1("ss_led", 1'b1, leds[0]);
    chk1("smbus_data_rx", 1'b1, s_drx);
    tick(1);
    cfg_v <= 1'b1;
    tick(3);
    @(negedge clock_in);
    chk1("lp_initiate", 1'b1, ini);
    tick(1);
    dis_b <= 1'b1;
    blk_b <= 1'b1;
    s_dat_oe <= 1'b1;
    tick(8);
    @(negedge clock_in);
    chk1("u1u2_disable", 1'b1, dis);
    chk1("lp_accept", 1'b0, acc);
    chk1("init_block", 1'b1, blk);
    chk1("serial_data_oe", 1'b1, oes[2]);
    chk1("smbus_data_rx", 1'b0, s_drx);
    chk1("eeprom_data_rx", 1'b1, e_drx);
    summarize();
  end
endmodule

`default_nettype wire
